/* File: fcap_pkg.sv */
package fcap_pkg;

   localparam int CLK_PERIOD_NS = 40;
   localparam int T_WP_NS       = 45;
   localparam int T_ACC_NS      = 150;
   localparam int SYNC_STAGES   = 2;

   // least times round up to whole cycles
   localparam logic [2:0] WP_CYC  = 3'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [2:0] ACC_CYC = 3'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [2:0] RD_CYC  = 3'(ACC_CYC + 3'(SYNC_STAGES));

   localparam int ADDR_W = 18;
   localparam int PIN_W  = 19;
   localparam int DATA_W = 16;

   localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 18'h00555;
   localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 18'h002aa;
   localparam logic [ADDR_W-1:0] RESET_ADDR   = 18'h00000;
   localparam logic [7:0]        UNLOCK1_DATA = 8'haa;
   localparam logic [7:0]        UNLOCK2_DATA = 8'h55;
   localparam logic [7:0]        CMD_AUTOSEL  = 8'h90;
   localparam logic [7:0]        CMD_RESET    = 8'hf0;

   localparam logic [11:0] PROT_OFS_WORD = 12'h002;
   localparam logic [12:0] PROT_OFS_BYTE = 13'h0004;

   localparam int NUM_SECT = 11;
   // A17:A12 of each sector base, bottom-boot map
   localparam logic [5:0] SECT_BASE [0:NUM_SECT-1] = '{6'h00, 6'h02, 6'h03, 6'h04, 6'h08,
                                                       6'h10, 6'h18, 6'h20, 6'h28, 6'h30, 6'h38};

   typedef enum logic [2:0] {OP_READ, OP_WRITE, OP_RESET, OP_AUTOSEL, OP_PROT_CHECK, OP_HV_READ} fcap_op_t;

endpackage

/* File: fcap_cyc_if.sv */
`timescale 1ns/1ps
interface fcap_cyc_if;
   logic        req;
   logic        wr;
   logic        byte_mode;
   logic [18:0] pins;
   logic [15:0] wdata;
   logic        done;
   logic [15:0] rdata;

   modport master (output req, output wr, output byte_mode, output pins, output wdata,
                   input done, input rdata);
   modport engine (input req, input wr, input byte_mode, input pins, input wdata,
                   output done, output rdata);
endinterface

/* File: fcap_bus_cycle.sv */
`timescale 1ns/1ps
module fcap_bus_cycle
   import fcap_pkg::*;
(
   input  wire logic                        i_ref_clk,
   input  wire logic                        i_reset_n,
   fcap_cyc_if.engine                       cyc,
   input  wire logic [fcap_pkg::DATA_W-1:0] i_dq_in,
   output logic                             o_ce_n,
   output logic                             o_oe_n,
   output logic                             o_we_n,
   output logic [fcap_pkg::ADDR_W-1:0]      o_addr,
   output logic [fcap_pkg::DATA_W-1:0]      o_dq_out,
   output logic                             o_dq_oe_lo,
   output logic                             o_dq_oe_hi,
   output logic                             o_dq15_oe
);
   typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} fcap_est_t;

   fcap_est_t   st_reg;
   logic [2:0]  cnt_reg;
   logic        wr_reg;
   logic        byte_reg;
   logic        done_reg;
   logic [15:0] rdata_reg;
   logic [15:0] dq_s1_reg;
   logic [15:0] dq_s2_reg;

   assign cyc.done  = done_reg;
   assign cyc.rdata = rdata_reg;

   // data pins come from the device, outside our timing
   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         dq_s1_reg <= 16'h0000;
         dq_s2_reg <= 16'h0000;
      end
      else
      begin
         dq_s1_reg <= i_dq_in;
         dq_s2_reg <= dq_s1_reg;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         st_reg     <= E_IDLE;
         cnt_reg    <= 3'h0;
         wr_reg     <= 1'b0;
         byte_reg   <= 1'b0;
         done_reg   <= 1'b0;
         rdata_reg  <= 16'h0000;
         o_ce_n     <= 1'b1;
         o_oe_n     <= 1'b1;
         o_we_n     <= 1'b1;
         o_addr     <= 18'h00000;
         o_dq_out   <= 16'h0000;
         o_dq_oe_lo <= 1'b0;
         o_dq_oe_hi <= 1'b0;
         o_dq15_oe  <= 1'b0;
      end
      else
      begin
         unique case (st_reg)
            E_IDLE:
            begin
               done_reg <= 1'b0;
               if (cyc.req)
               begin
                  // address settles a full cycle before either strobe falls
                  o_ce_n     <= 1'b0;
                  o_addr     <= cyc.pins[18:1];
                  o_dq_out   <= {cyc.byte_mode ? cyc.pins[0] : cyc.wdata[15], cyc.wdata[14:0]};
                  o_dq_oe_lo <= cyc.wr;
                  o_dq_oe_hi <= cyc.wr & ~cyc.byte_mode;
                  o_dq15_oe  <= cyc.byte_mode;
                  wr_reg     <= cyc.wr;
                  byte_reg   <= cyc.byte_mode;
                  st_reg     <= E_SETUP;
               end
            end
            E_SETUP:
            begin
               // write strobe only with output gate high, never both low
               if (wr_reg)
               begin
                  o_we_n  <= 1'b0;
                  cnt_reg <= WP_CYC - 3'h1;
               end
               else
               begin
                  o_oe_n  <= 1'b0;
                  cnt_reg <= RD_CYC - 3'h1;
               end
               st_reg <= E_STROBE;
            end
            E_STROBE:
            begin
               if (cnt_reg == 3'h0)
               begin
                  o_we_n    <= 1'b1;
                  o_oe_n    <= 1'b1;
                  rdata_reg <= byte_reg ? {8'h00, dq_s2_reg[7:0]} : dq_s2_reg;
                  st_reg    <= E_HOLD;
               end
               else
               begin
                  cnt_reg <= cnt_reg - 3'h1;
               end
            end
            E_HOLD:
            begin
               // data and address held one cycle past the rising write strobe
               o_ce_n     <= 1'b1;
               o_dq_oe_lo <= 1'b0;
               o_dq_oe_hi <= 1'b0;
               o_dq15_oe  <= 1'b0;
               done_reg   <= 1'b1;
               st_reg     <= E_IDLE;
            end
         endcase
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   sequence s_we_pulse;
      !o_we_n [*2] ##1 o_we_n;
   endsequence

   a_write_gate: assert property (!o_we_n |-> !o_ce_n && o_oe_n)
      else $error("write strobe low without chip select low and output gate high");
   a_addr_steady: assert property ($fell(o_we_n) |-> $stable(o_addr) [*3])
      else $error("address moved during write strobe");
   a_wp_width: assert property ($fell(o_we_n) |-> s_we_pulse ##1 o_ce_n)
      else $error("write pulse width or hold wrong");
   a_data_hold: assert property ($rose(o_we_n) |-> o_dq_oe_lo && $stable(o_dq_out))
      else $error("write data not held past rising strobe");
   a_read_len: assert property ($fell(o_oe_n) |-> !o_oe_n [*6] ##1 o_oe_n)
      else $error("read strobe length wrong");
   a_done_bound: assert property (st_reg == E_IDLE && cyc.req |-> ##[4:9] done_reg)
      else $error("bus cycle did not finish in time");

endmodule // fcap_bus_cycle

/* File: fcap_host.sv */
`timescale 1ns/1ps
module fcap_host
   import fcap_pkg::*;
(
   input  wire logic                        i_ref_clk,
   input  wire logic                        i_reset_n,
   input  wire logic                        i_op_valid,
   input  wire fcap_pkg::fcap_op_t          i_op,
   input  wire logic [fcap_pkg::PIN_W-1:0]  i_addr,
   input  wire logic [fcap_pkg::DATA_W-1:0] i_wdata,
   input  wire logic [3:0]                  i_sector,
   input  wire logic                        i_byte_mode,
   input  wire logic                        i_temp_unprotect,
   input  wire logic [fcap_pkg::DATA_W-1:0] i_dq_in,
   output logic                             o_op_ready,
   output logic                             o_done,
   output logic [fcap_pkg::DATA_W-1:0]      o_rdata,
   output logic                             o_protected,
   output logic                             o_in_autosel,
   output logic                             o_ce_n,
   output logic                             o_oe_n,
   output logic                             o_we_n,
   output logic [fcap_pkg::ADDR_W-1:0]      o_addr,
   output logic [fcap_pkg::DATA_W-1:0]      o_dq_out,
   output logic                             o_dq_oe_lo,
   output logic                             o_dq_oe_hi,
   output logic                             o_dq15_oe,
   output logic                             o_byte_n,
   output logic                             o_flash_reset_n,
   output logic                             o_reset_hv_en,
   output logic                             o_hv_sense_line_en
);
   typedef enum logic [2:0] {S_IDLE, S_PRE_RESET, S_UNLOCK1, S_UNLOCK2, S_CMD, S_ACCESS, S_WAIT} fcap_st_t;

   fcap_st_t    state_reg;
   fcap_st_t    after_reg;
   fcap_op_t    op_reg;
   logic [18:0] addr_reg;
   logic [15:0] wdata_reg;
   logic [5:0]  sect_base_reg;
   logic        byte_reg;
   logic        req_reg;
   logic        wr_reg;
   logic [18:0] pins_reg;
   logic [15:0] cyc_data_reg;
   logic        rst_cyc_reg;
   logic        asel_cyc_reg;
   logic [18:0] prot_pins;

   fcap_cyc_if cyc ();

   assign cyc.req       = req_reg;
   assign cyc.wr        = wr_reg;
   assign cyc.byte_mode = byte_reg;
   assign cyc.pins      = pins_reg;
   assign cyc.wdata     = cyc_data_reg;

   // sector base on A17:A12, protection offset below it
   assign prot_pins = byte_reg ? {sect_base_reg, PROT_OFS_BYTE}
                               : {sect_base_reg, PROT_OFS_WORD, 1'b0};

   fcap_bus_cycle u_bus_cycle (
      .i_ref_clk  (i_ref_clk),
      .i_reset_n  (i_reset_n),
      .cyc        (cyc),
      .i_dq_in    (i_dq_in),
      .o_ce_n     (o_ce_n),
      .o_oe_n     (o_oe_n),
      .o_we_n     (o_we_n),
      .o_addr     (o_addr),
      .o_dq_out   (o_dq_out),
      .o_dq_oe_lo (o_dq_oe_lo),
      .o_dq_oe_hi (o_dq_oe_hi),
      .o_dq15_oe  (o_dq15_oe)
   );

   // pin levels that only follow the user's settings
   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_flash_reset_n <= 1'b0;
         o_reset_hv_en   <= 1'b0;
         o_byte_n        <= 1'b1;
         byte_reg        <= 1'b0;
      end
      else
      begin
         o_flash_reset_n <= 1'b1;
         o_reset_hv_en   <= i_temp_unprotect;
         // width only changes between operations so a cycle never sees it move
         if (state_reg == S_IDLE)
         begin
            byte_reg <= i_byte_mode;
            o_byte_n <= ~i_byte_mode;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state_reg     <= S_IDLE;
         after_reg     <= S_IDLE;
         op_reg        <= OP_READ;
         addr_reg      <= 19'h00000;
         wdata_reg     <= 16'h0000;
         sect_base_reg <= 6'h00;
         req_reg       <= 1'b0;
         wr_reg        <= 1'b0;
         pins_reg      <= 19'h00000;
         cyc_data_reg  <= 16'h0000;
         rst_cyc_reg   <= 1'b0;
         asel_cyc_reg  <= 1'b0;
         o_op_ready    <= 1'b0;
         o_done        <= 1'b0;
         o_rdata       <= 16'h0000;
         o_protected   <= 1'b0;
         o_hv_sense_line_en <= 1'b0;
      end
      else
      begin
         req_reg <= 1'b0;
         o_done  <= 1'b0;
         unique case (state_reg)
            S_IDLE:
            begin
               o_op_ready <= 1'b1;
               if (i_op_valid && o_op_ready)
               begin
                  o_op_ready    <= 1'b0;
                  op_reg        <= i_op;
                  addr_reg      <= i_addr;
                  wdata_reg     <= i_wdata;
                  // out-of-range sector numbers fold onto the last sector
                  sect_base_reg <= SECT_BASE[(i_sector < 4'(NUM_SECT)) ? i_sector : 4'(NUM_SECT - 1)];
                  o_hv_sense_line_en <= (i_op == OP_HV_READ);
                  // array access from autoselect needs a reset first
                  if (o_in_autosel && (i_op == OP_READ || i_op == OP_WRITE))
                     state_reg <= S_PRE_RESET;
                  else if (i_op == OP_AUTOSEL)
                     state_reg <= S_UNLOCK1;
                  else if (i_op == OP_RESET)
                     state_reg <= S_CMD;
                  else
                     state_reg <= S_ACCESS;
               end
            end
            S_PRE_RESET:
            begin
               req_reg      <= 1'b1;
               wr_reg       <= 1'b1;
               pins_reg     <= {RESET_ADDR, 1'b0};
               cyc_data_reg <= {8'h00, CMD_RESET};
               rst_cyc_reg  <= 1'b1;
               asel_cyc_reg <= 1'b0;
               after_reg    <= S_ACCESS;
               state_reg    <= S_WAIT;
            end
            S_UNLOCK1:
            begin
               req_reg      <= 1'b1;
               wr_reg       <= 1'b1;
               pins_reg     <= {UNLOCK1_ADDR, 1'b0};
               cyc_data_reg <= {8'h00, UNLOCK1_DATA};
               rst_cyc_reg  <= 1'b0;
               asel_cyc_reg <= 1'b0;
               after_reg    <= S_UNLOCK2;
               state_reg    <= S_WAIT;
            end
            S_UNLOCK2:
            begin
               req_reg      <= 1'b1;
               wr_reg       <= 1'b1;
               pins_reg     <= {UNLOCK2_ADDR, 1'b0};
               cyc_data_reg <= {8'h00, UNLOCK2_DATA};
               after_reg    <= S_CMD;
               state_reg    <= S_WAIT;
            end
            S_CMD:
            begin
               req_reg      <= 1'b1;
               wr_reg       <= 1'b1;
               rst_cyc_reg  <= (op_reg == OP_RESET);
               asel_cyc_reg <= (op_reg == OP_AUTOSEL);
               pins_reg     <= (op_reg == OP_AUTOSEL) ? {UNLOCK1_ADDR, 1'b0} : {RESET_ADDR, 1'b0};
               cyc_data_reg <= {8'h00, (op_reg == OP_AUTOSEL) ? CMD_AUTOSEL : CMD_RESET};
               after_reg    <= S_IDLE;
               state_reg    <= S_WAIT;
            end
            S_ACCESS:
            begin
               req_reg      <= 1'b1;
               wr_reg       <= (op_reg == OP_WRITE);
               pins_reg     <= (op_reg == OP_PROT_CHECK) ? prot_pins : addr_reg;
               cyc_data_reg <= wdata_reg;
               rst_cyc_reg  <= 1'b0;
               asel_cyc_reg <= 1'b0;
               after_reg    <= S_IDLE;
               state_reg    <= S_WAIT;
            end
            S_WAIT:
            begin
               if (cyc.done)
               begin
                  state_reg <= after_reg;
                  if (after_reg == S_IDLE)
                  begin
                     o_done      <= 1'b1;
                     o_rdata     <= cyc.rdata;
                     o_protected <= cyc.rdata[0];
                     o_hv_sense_line_en <= 1'b0;
                  end
               end
            end
            default:
            begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

   // mirrors the device: autoselect holds until a reset command is written
   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_in_autosel <= 1'b0;
      else if (state_reg == S_WAIT && cyc.done)
      begin
         if (asel_cyc_reg)
            o_in_autosel <= 1'b1;
         else if (rst_cyc_reg)
            o_in_autosel <= 1'b0;
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   sequence s_take_read_in_asel;
      state_reg == S_IDLE && o_op_ready && i_op_valid && o_in_autosel && i_op == OP_READ;
   endsequence

   a_asel_reset: assert property (s_take_read_in_asel |=> state_reg == S_PRE_RESET
                                  ##1 req_reg && pins_reg == {RESET_ADDR, 1'b0} && cyc_data_reg == {8'h00, CMD_RESET})
      else $error("array read from autoselect not preceded by reset command");
   a_asel_entry: assert property ($rose(o_in_autosel) |-> $past(cyc_data_reg) == 16'h0090
                                  && $past(pins_reg) == 19'h00aaa)
      else $error("autoselect entered without autoselect command");
   a_unlock_order: assert property (state_reg == S_UNLOCK1 |=> req_reg && cyc_data_reg == 16'h00aa
                                    ##[6:12] req_reg && cyc_data_reg == 16'h0055)
      else $error("unlock cycles out of order");
   a_hv_only_id: assert property (o_hv_sense_line_en |-> op_reg == OP_HV_READ)
      else $error("high voltage on sense line outside identification read");
   a_prot_addr: assert property (req_reg && op_reg == OP_PROT_CHECK |-> pins_reg[12:0] == 13'h0004)
      else $error("protection check address offset wrong");
   a_done_result: assert property (state_reg == S_WAIT && cyc.done && after_reg == S_IDLE
                                   |=> o_done && o_rdata == $past(cyc.rdata) && o_protected == $past(cyc.rdata[0]))
      else $error("protection answer not taken from data bit");
   a_unprot_follow: assert property (i_temp_unprotect |=> o_reset_hv_en)
      else $error("temporary unprotect level not driven");

endmodule // fcap_host

/* File: fcap_flash_model.sv */
`timescale 1ns/1ps
module fcap_flash_model #(
   parameter logic [10:0] PROT_MASK = 11'h005,
   parameter logic [7:0]  MFR_CODE  = 8'h3c,
   parameter logic [7:0]  DEV_CODE  = 8'h7e
) (
   input  wire logic        i_ce_n,
   input  wire logic        i_oe_n,
   input  wire logic        i_we_n,
   input  wire logic        i_rst_n,
   input  wire logic        i_rst_hv,
   input  wire logic        i_hv_sense_line,
   input  wire logic        i_byte_n,
   input  wire logic [17:0] i_addr,
   input  wire logic [15:0] i_dq,
   output logic      [15:0] o_dq
);
   // both identifier codes are arbitrary values
   logic [17:0] lat = '0;
   logic [1:0]  step = '0;
   logic        asel = 1'b0;
   logic [17:0] pa = '0;
   logic [15:0] pd = '0;
   logic        pv = 1'b0;
   logic [15:0] rd;
   logic [3:0]  s;
   wire         wr = !i_ce_n && !i_we_n && i_oe_n;
   always_comb
   begin
      if (i_addr[17:15] != 3'h0) s = 4'(3 + i_addr[17:15]);
      else if (i_addr[14]) s = 4'h3;
      else if (i_addr[13]) s = {3'h0, i_addr[12]} + 4'h1;
      else s = 4'h0;
      if (!(asel || i_hv_sense_line)) rd = (pv && i_addr == pa) ? pd : i_addr[15:0] ^ 16'ha5c3;
      else if (i_addr[1:0] == 2'h0) rd = {8'h00, MFR_CODE};
      else if (i_addr[1:0] == 2'h1) rd = {8'h00, DEV_CODE};
      else rd = {15'h0, PROT_MASK[s] & !i_rst_hv};
      // a released bus must not hold its old value, so show the inverse
      o_dq = (!i_ce_n && !i_oe_n && i_rst_n) ? rd : ~rd;
      if (!i_byte_n) o_dq[14:8] = ~rd[14:8];
   end
   always @(posedge wr) lat = i_addr;
   always @(negedge wr or negedge i_rst_n)
   begin
      if (!i_rst_n || i_dq[7:0] == 8'hf0)
      begin
         step = 2'h0;
         asel = 1'b0;
      end
      else if (step == 2'h0 && lat[10:0] == 11'h555 && i_dq[7:0] == 8'haa) step = 2'h1;
      else if (step == 2'h1 && lat[10:0] == 11'h2aa && i_dq[7:0] == 8'h55) step = 2'h2;
      else if (step == 2'h2 && lat[10:0] == 11'h555 && i_dq[7:0] == 8'h90)
      begin
         step = 2'h0;
         asel = 1'b1;
      end
      else if (step == 2'h2 && lat[10:0] == 11'h555 && i_dq[7:0] == 8'ha0) step = 2'h3;
      else if (step == 2'h3)
      begin
         // one remembered word is enough to show a program landed or was refused
         if (!(PROT_MASK[s] && !i_rst_hv))
         begin
            pa = lat;
            pd = i_dq;
            pv = 1'b1;
         end
         step = 2'h0;
      end
      else step = 2'h0;
   end
endmodule // fcap_flash_model

/* File: fcap_host_tb.sv */
`timescale 1ns/1ps
module fcap_host_tb;
   import fcap_pkg::*;
   localparam logic [10:0] PM = 11'h005;
   localparam logic [7:0]  MC = 8'h3c;  // arbitrary value
   localparam logic [7:0]  DC = 8'h7e;  // arbitrary value
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        valid = 1'b0;
   logic        bm = 1'b0;
   logic        tu = 1'b0;
   fcap_op_t    op = OP_READ;
   logic [18:0] a = '0;
   logic [15:0] wd = '0;
   logic [3:0]  sec = '0;
   logic [15:0] dqo, dqm, rd;
   logic [17:0] fa;
   logic        rdy, done, prot, insel, ce_n, oe_n, we_n, oel, oeh, oe15, byte_n, frst_n, hv_rst, hv_sense;
   logic [18:0] pg;
   int          errors = 0;
   int          samples_checked = 0;
   wire  [15:0] dqi = {(oeh | oe15) ? dqo[15] : dqm[15], oeh ? dqo[14:8] : dqm[14:8], oel ? dqo[7:0] : dqm[7:0]};
   always #20 clk = ~clk;
   fcap_host dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_op_valid(valid), .i_op(op), .i_addr(a), .i_wdata(wd),
      .i_sector(sec), .i_byte_mode(bm), .i_temp_unprotect(tu), .i_dq_in(dqi), .o_op_ready(rdy), .o_done(done),
      .o_rdata(rd), .o_protected(prot), .o_in_autosel(insel), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n),
      .o_addr(fa), .o_dq_out(dqo), .o_dq_oe_lo(oel), .o_dq_oe_hi(oeh), .o_dq15_oe(oe15), .o_byte_n(byte_n),
      .o_flash_reset_n(frst_n), .o_reset_hv_en(hv_rst), .o_hv_sense_line_en(hv_sense));
   fcap_flash_model #(.PROT_MASK(PM), .MFR_CODE(MC), .DEV_CODE(DC)) flash (.i_ce_n(ce_n), .i_oe_n(oe_n),
      .i_we_n(we_n), .i_rst_n(frst_n), .i_rst_hv(hv_rst), .i_hv_sense_line(hv_sense), .i_byte_n(byte_n), .i_addr(fa),
      .i_dq(dqi), .o_dq(dqm));
   task automatic final_report;
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   function automatic logic [15:0] arr(input logic [18:0] ad);
      return ad[16:1] ^ 16'ha5c3;
   endfunction
   task automatic run(input fcap_op_t o, input logic [18:0] ad, input logic [15:0] d, input logic [3:0] s);
      int n;
      for (n = 0; n < 100 && rdy !== 1'b1; n++) @(negedge clk);
      if (rdy !== 1'b1)
      begin
         errors++;
         $display("wrong value at %0t: never ready", $time);
         final_report();
      end
      op = o;
      a = ad;
      wd = d;
      sec = s;
      valid = 1'b1;
      @(negedge clk);
      valid = 1'b0;
      for (n = 0; n < 100 && done !== 1'b1; n++) @(negedge clk);
      if (done !== 1'b1)
      begin
         errors++;
         $display("wrong value at %0t: operation hung", $time);
         final_report();
      end
   endtask
   task automatic prog(input logic [18:0] ad, input logic [15:0] d);
      run(OP_WRITE, 19'h00aaa, 16'h00aa, 4'h0);
      run(OP_WRITE, 19'h00554, 16'h0055, 4'h0);
      run(OP_WRITE, 19'h00aaa, 16'h00a0, 4'h0);
      run(OP_WRITE, ad, d, 4'h0);
   endtask
   initial
   begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      chk(16'(frst_n), 16'h1, "reset pin");
      run(OP_READ, 19'h02468, 16'h0, 4'h0);
      chk(rd, arr(19'h02468), "power-up read");
      for (int k = 0; k < 3; k++)
      begin
         run(OP_WRITE, 19'h00aaa, 16'h00aa, 4'h0);
         run(OP_WRITE, 19'h00554, (k == 2) ? 16'h0056 : 16'h0055, 4'h0);
         if (k == 1) run(OP_RESET, 19'h0, 16'h0, 4'h0);
         run(OP_WRITE, 19'h00aaa, 16'h0090, 4'h0);
         run(OP_READ, 19'h00002, 16'h0, 4'h0);
         chk(rd, (k == 0) ? {8'h00, DC} : arr(19'h00002), "command id");
         run(OP_RESET, 19'h0, 16'h0, 4'h0);
         run(OP_READ, 19'h00002, 16'h0, 4'h0);
         chk(rd, arr(19'h00002), "after reset");
      end
      run(OP_AUTOSEL, 19'h0, 16'h0, 4'h0);
      chk(16'(insel), 16'h1, "autoselect");
      for (int s = 0; s < 11; s++)
      begin
         bm = s[0];
         run(OP_PROT_CHECK, 19'h0, 16'h0, 4'(s));
         chk({rd[15:1], prot}, {15'h0, PM[s]}, "protect flag");
      end
      bm = 1'b0;
      run(OP_READ, 19'h02468, 16'h0, 4'h0);
      chk(rd, arr(19'h02468), "leave autoselect");
      chk(16'(insel), 16'h0, "autoselect flag");
      for (int j = 0; j < 3; j++)
      begin
         tu = (j == 2);
         pg = (j == 0) ? 19'h04000 : (j == 1) ? 19'h00100 : 19'h06000;
         prog(pg, 16'h1234 + 16'(j));
         run(OP_READ, pg, 16'h0, 4'h0);
         chk(rd, (j == 1) ? arr(pg) : 16'h1234 + 16'(j), "program gate");
      end
      tu = 1'b0;
      for (int i = 0; i < 3; i++)
      begin
         run(OP_HV_READ, 19'(i * 2), 16'h0, 4'h0);
         chk(rd, (i == 0) ? {8'h00, MC} : (i == 1) ? {8'h00, DC} : {15'h0, PM[0]}, "hv id");
      end
      tu = 1'b1;
      run(OP_AUTOSEL, 19'h0, 16'h0, 4'h0);
      run(OP_PROT_CHECK, 19'h0, 16'h0, 4'h2);
      chk({14'h0, hv_rst, prot}, 16'h2, "temp unprotect");
      tu = 1'b0;
      run(OP_PROT_CHECK, 19'h0, 16'h0, 4'h2);
      chk({14'h0, hv_rst, prot}, 16'h1, "protect back");
      run(OP_RESET, 19'h0, 16'h0, 4'h0);
      chk(16'(insel), 16'h0, "reset op");
      run(OP_AUTOSEL, 19'h0, 16'h0, 4'h0);
      rst_n = 1'b0;
      @(negedge clk);
      chk({13'h0, rdy, insel, frst_n}, 16'h0, "mid-run reset");
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      run(OP_READ, 19'h02468, 16'h0, 4'h0);
      chk(rd, arr(19'h02468), "read after reset");
      final_report();
   end
endmodule // fcap_host_tb
